//--- design/ppg_gate_hold.v
// Sample holder: captures a new value only while its function is on.
// Assumes data and valid come from the same clock as pclk.
`timescale 1ns/1ps

module ppg_gate_hold #(
	parameter WIDTH = 16
) (
	input wire pclk,
	input wire presetn,
	input wire enable,
	input wire valid,
	input wire [WIDTH-1:0] data,
	output wire [WIDTH-1:0] held
);

	reg [WIDTH-1:0] held_reg;

	// Freezes on the last value while disabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_reg <= {WIDTH{1'b0}};
		end else if (enable && valid) begin
			held_reg <= data;
		end
	end

	assign held = held_reg;

endmodule // ppg_gate_hold

//--- design/ppg_power_gate.v
// Peripheral power gating register with its gated datapaths.
// Assumes an APB master on pclk; all other inputs are synchronous to pclk.
`timescale 1ns/1ps
`include "ppg_consts.vh"

module ppg_power_gate (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`PPG_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [`PPG_MIC_CH-1:0] mic_valid,
	input wire [`PPG_MIC_CH*`PPG_MIC_W-1:0] mic_sample_in,
	output wire [`PPG_MIC_CH*`PPG_MIC_W-1:0] mic_sample_out,
	input wire [`PPG_AUX_CH-1:0] aux_valid,
	input wire [`PPG_AUX_CH*`PPG_AUX_W-1:0] aux_result_in,
	output wire [`PPG_AUX_CH*`PPG_AUX_W-1:0] aux_result_out,
	input wire spdif_tx_serial,
	output wire spdif_out_pin,
	input wire spdif_in_pin,
	output wire spdif_in_stream,
	output wire spdif_rx_recover_en,
	output wire mic_pair_a_on,
	output wire mic_pair_b_on,
	output wire spdif_out_on,
	output wire spdif_in_on,
	output wire aux_converter_on
);

	reg [`PPG_GATE_WIDTH-1:0] peripheral_power_gate_reg;
	reg [`PPG_GATE_WIDTH-1:0] peripheral_power_gate_next;
	reg [31:0] prdata_reg;
	reg pready_reg;
	reg pslverr_reg;
	reg [4:0] enable_reg;
	reg spdif_out_reg;
	reg spdif_in_reg;
	reg recover_reg;

	wire setup_phase;
	wire access_done;
	wire addr_hit;
	wire wr_hit;
	wire [`PPG_MIC_CH-1:0] mic_enable;
	wire [`PPG_AUX_CH*`PPG_AUX_W-1:0] aux_held;
	wire [`PPG_MIC_CH*`PPG_MIC_W-1:0] mic_held;

	// APB decode
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign addr_hit = (paddr == `PPG_GATE_ADDR);
	assign wr_hit = access_done && pwrite && addr_hit;

	// Byte lane merge of a write; all 16 bits stored as written
	always @* begin
		peripheral_power_gate_next = peripheral_power_gate_reg;
		if (wr_hit) begin
			if (pstrb[0]) begin
				peripheral_power_gate_next[7:0] = pwdata[7:0];
			end
			if (pstrb[1]) begin
				peripheral_power_gate_next[15:8] = pwdata[15:8];
			end
		end
	end

	// Register storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_power_gate_reg <= `PPG_GATE_RESET;
		end else begin
			peripheral_power_gate_reg <= peripheral_power_gate_next;
		end
	end

	// Answer: ready one cycle after setup, so no wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else if (setup_phase) begin
			pready_reg <= 1'b1;
			pslverr_reg <= !addr_hit;
			if (!pwrite && addr_hit) begin
				prdata_reg <= {16'h0000, peripheral_power_gate_reg};
			end else begin
				prdata_reg <= 32'h00000000;
			end
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// Enables follow the register one edge after the write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= 5'h00;
		end else begin
			enable_reg <= peripheral_power_gate_reg[4:0];
		end
	end

	assign aux_converter_on = enable_reg[`PPG_BIT_AUX];
	assign spdif_in_on = enable_reg[`PPG_BIT_SPDIF_IN];
	assign spdif_out_on = enable_reg[`PPG_BIT_SPDIF_OUT];
	assign mic_pair_a_on = enable_reg[`PPG_BIT_MIC_A];
	assign mic_pair_b_on = enable_reg[`PPG_BIT_MIC_B];

	// Pair a holds channels 0 and 1, pair b channels 2 and 3
	assign mic_enable[0] = enable_reg[`PPG_BIT_MIC_A];
	assign mic_enable[1] = enable_reg[`PPG_BIT_MIC_A];
	assign mic_enable[2] = enable_reg[`PPG_BIT_MIC_B];
	assign mic_enable[3] = enable_reg[`PPG_BIT_MIC_B];

	genvar i;
	generate
		for (i = 0; i < `PPG_MIC_CH; i = i + 1) begin : g_mic
			// Sample freezes while the pair is off
			ppg_gate_hold #(
				.WIDTH(`PPG_MIC_W)
			) u_mic_hold (
				.pclk(pclk),
				.presetn(presetn),
				.enable(mic_enable[i]),
				.valid(mic_valid[i]),
				.data(mic_sample_in[i*`PPG_MIC_W +: `PPG_MIC_W]),
				.held(mic_held[i*`PPG_MIC_W +: `PPG_MIC_W])
			);
		end
		for (i = 0; i < `PPG_AUX_CH; i = i + 1) begin : g_aux
			// Result keeps its last value while converters are off
			ppg_gate_hold #(
				.WIDTH(`PPG_AUX_W)
			) u_aux_hold (
				.pclk(pclk),
				.presetn(presetn),
				.enable(enable_reg[`PPG_BIT_AUX]),
				.valid(aux_valid[i]),
				.data(aux_result_in[i*`PPG_AUX_W +: `PPG_AUX_W]),
				.held(aux_held[i*`PPG_AUX_W +: `PPG_AUX_W])
			);
		end
	endgenerate

	assign mic_sample_out = mic_held;
	assign aux_result_out = aux_held;

	// Transmitter pin forced low while off
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spdif_out_reg <= 1'b0;
		end else if (enable_reg[`PPG_BIT_SPDIF_OUT]) begin
			spdif_out_reg <= spdif_tx_serial;
		end else begin
			spdif_out_reg <= 1'b0;
		end
	end

	assign spdif_out_pin = spdif_out_reg;

	// Receiver stream and recovery stop while off, resume on re-enable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spdif_in_reg <= 1'b0;
			recover_reg <= 1'b0;
		end else begin
			recover_reg <= enable_reg[`PPG_BIT_SPDIF_IN];
			if (enable_reg[`PPG_BIT_SPDIF_IN]) begin
				spdif_in_reg <= spdif_in_pin;
			end else begin
				spdif_in_reg <= 1'b0;
			end
		end
	end

	assign spdif_in_stream = spdif_in_reg;
	assign spdif_rx_recover_en = recover_reg;

endmodule // ppg_power_gate

//--- inc/ppg_consts.vh
// Constants for the peripheral power gating register bank.
// Assumes inclusion by bare name from the design files.
`ifndef PPG_CONSTS_VH
`define PPG_CONSTS_VH

// Printed register index; the byte address is four times the index
`define PPG_GATE_INDEX 20'h0f051
`define PPG_GATE_ADDR 20'h3c144
`define PPG_GATE_RESET 16'h0000
`define PPG_GATE_WIDTH 16

// Field positions
`define PPG_BIT_AUX 0
`define PPG_BIT_SPDIF_IN 1
`define PPG_BIT_SPDIF_OUT 2
`define PPG_BIT_MIC_A 3
`define PPG_BIT_MIC_B 4

// Datapath sizes
`define PPG_ADDR_W 20
`define PPG_MIC_CH 4
`define PPG_MIC_W 24
`define PPG_AUX_CH 2
`define PPG_AUX_W 12

`endif

//--- verification/ppg_props.sv
// Checker for the power gating register bank.
// Assumes it is bound to ppg_power_gate and sees only its ports.
`timescale 1ns/1ps
module ppg_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire spdif_tx_serial,
	input wire spdif_out_pin,
	input wire spdif_out_on,
	input wire spdif_in_on,
	input wire spdif_rx_recover_en,
	input wire aux_converter_on,
	input wire [23:0] aux_result_out,
	input wire mic_pair_a_on,
	input wire mic_pair_b_on,
	input wire [95:0] mic_sample_out
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_setup;
	psel && !penable;
endsequence
ack_once_a: assert property (s_setup |=> pready ##1 !pready)
	else $error("ack missing or too long");
err_ack_a: assert property (pslverr |-> pready)
	else $error("error without ack");
tx_low_a: assert property (!spdif_out_on && !$past(spdif_out_on) |-> !spdif_out_pin)
	else $error("tx pin not low");
tx_pass_a: assert property (spdif_out_on && $past(spdif_out_on)
	|-> spdif_out_pin == $past(spdif_tx_serial))
	else $error("tx pin wrong");
rx_lag_a: assert property (spdif_rx_recover_en == $past(spdif_in_on))
	else $error("recovery enable wrong");
aux_hold_a: assert property (!$past(aux_converter_on) |-> $stable(aux_result_out))
	else $error("aux result moved");
mic_a_hold_a: assert property (!$past(mic_pair_a_on) |-> $stable(mic_sample_out[47:0]))
	else $error("mic pair a moved");
mic_b_hold_a: assert property (!$past(mic_pair_b_on) |-> $stable(mic_sample_out[95:48]))
	else $error("mic pair b moved");
endmodule // ppg_props

bind ppg_power_gate ppg_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .spdif_tx_serial(spdif_tx_serial),
	.spdif_out_pin(spdif_out_pin), .spdif_out_on(spdif_out_on), .spdif_in_on(spdif_in_on),
	.spdif_rx_recover_en(spdif_rx_recover_en), .aux_converter_on(aux_converter_on),
	.aux_result_out(aux_result_out), .mic_pair_a_on(mic_pair_a_on),
	.mic_pair_b_on(mic_pair_b_on), .mic_sample_out(mic_sample_out));

//--- verification/tb_top.sv
// Testbench for the power gating register bank.
// Assumes the design and its constants header are on the include path.
`timescale 1ns/1ps
`include "ppg_consts.vh"
module tb_top;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx = 0, e;
logic [19:0] paddr = 0;
logic [31:0] pwdata = 0, rd;
logic [23:0] cnt = 0, va;
logic [3:0] strb = 4'hf;
logic [95:0] v;
wire [31:0] prdata;
wire pready, pslverr, opin, istr, rec;
wire [4:0] on;
wire [95:0] mo;
wire [23:0] ao;
int num_errors = 0, comparisons = 0;
always #20 pclk = ~pclk;
always @(posedge pclk) begin
	cnt <= cnt + 24'h1;
	tx <= ~tx;
end
ppg_power_gate DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .mic_valid(4'hf), .mic_sample_in({4{cnt}}),
	.mic_sample_out(mo), .aux_valid(2'h3), .aux_result_in({2{cnt[11:0]}}),
	.aux_result_out(ao), .spdif_tx_serial(tx), .spdif_out_pin(opin), .spdif_in_pin(tx),
	.spdif_in_stream(istr), .spdif_rx_recover_en(rec), .mic_pair_a_on(on[3]),
	.mic_pair_b_on(on[4]), .spdif_out_on(on[2]), .spdif_in_on(on[1]),
	.aux_converter_on(on[0]));
task chk(input string n, input logic [31:0] s, input logic [31:0] x);
	comparisons++;
	if (s !== x) begin
		num_errors++;
		$display("mismatch %s exp %h seen %h", n, x, s);
	end
endtask
task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	do @(posedge pclk); while (pready !== 1'b1);
	rd = prdata;
	e = pslverr;
	psel <= 0;
	penable <= 0;
	@(posedge pclk);
endtask
task t_reg;
	apb(0, `PPG_GATE_ADDR, 0);
	chk("reset", rd, 0);
	chk("noerr", e, 0);
	chk("ons", on, 0);
	apb(1, `PPG_GATE_ADDR, 32'hffffffff);
	apb(0, `PPG_GATE_ADDR, 0);
	chk("rw", rd, 32'hffff);
	chk("ons", on, 5'h1f);
	apb(1, 20'h0, 0);
	chk("err", e, 1);
	apb(0, `PPG_GATE_ADDR, 0);
	chk("kept", rd, 32'hffff);
	strb <= 4'h1;
	apb(1, `PPG_GATE_ADDR, 32'h0);
	strb <= 4'hf;
	apb(0, `PPG_GATE_ADDR, 0);
	chk("lane", rd, 32'hff00);
	chk("ons", on, 0);
	$display("register test done");
endtask
task t_gate;
	apb(1, `PPG_GATE_ADDR, 32'h8);
	repeat (3) @(posedge pclk);
	chk("mic_a", mo[23:0], {cnt - 24'h1});
	chk("ons", on, 5'h08);
	v = mo;
	va = ao;
	@(posedge pclk);
	chk("mic_b", mo[95:72], v[95:72]);
	chk("aux", ao, va);
	chk("tx", opin, 0);
	chk("rx", rec, 0);
	chk("rx_in", istr, 0);
	apb(1, `PPG_GATE_ADDR, 32'h17);
	repeat (3) @(posedge pclk);
	chk("mic_b", mo[71:48], {cnt - 24'h1});
	chk("aux", ao[11:0], {cnt[11:0] - 12'h1});
	chk("ons", on, 5'h17);
	chk("tx", opin, !tx);
	chk("rx", rec, 1);
	chk("rx_in", istr, !tx);
	v = mo;
	@(posedge pclk);
	chk("mic_a", mo[23:0], v[23:0]);
	$display("gating test done");
endtask
task finish_test;
	$display("comparisons %0d mismatches %0d", comparisons, num_errors);
	if (num_errors == 0 && comparisons > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
initial begin
	repeat (16) @(posedge pclk);
	presetn <= 1;
	@(posedge pclk);
	t_reg;
	t_gate;
	finish_test;
end
initial begin
	#200000;
	num_errors++;
	finish_test;
end
endmodule // tb_top
